// >>> core/dmc_map.svh
// Offsets, field positions, reset values and timing counts of the mute/attenuation control.
// Assumes inclusion by bare name; holds definitions only.
`ifndef DMC_MAP_SVH
`define DMC_MAP_SVH
`define DMC_CTRL_OFS 8'h00
`define DMC_ATT_OFS 8'h04
`define DMC_STAT_OFS 8'h08
`define DMC_CB_SMUTE 0
`define DMC_CB_FMUTE 1
`define DMC_CB_FPOL 2
`define DMC_CB_ZMUTE 3
`define DMC_CB_RESYNC 4
`define DMC_CB_SIGN 5
`define DMC_CB_BOOST 6
`define DMC_CB_BLEVEL 7
`define DMC_CB_MCLK 8
`define DMC_CB_PAGE 9
`define DMC_CTRL_RST 10'h004
`define DMC_ATT_RST 10'h3ff
`define DMC_ATT_W 10
`define DMC_RAMP_STEP 10'h001
`define DMC_BITS_PER_WORD 6'h30
`define DMC_SAMPLE_BITS 6'h18
`define DMC_ZERO_LSB 4
`define DMC_ZERO_MS 300
`define DMC_CLK_KHZ 40000
`endif

// >>> core/dmc_pkg.sv
// Types shared by the mute/attenuation control.
// Assumes the constant header is compiled alongside.
package dmc_pkg;
  typedef enum logic [1:0] {SYNC_WAIT, SYNC_LOCKED, SYNC_LOST} dmc_sync_t;
  typedef logic signed [23:0] dmc_sample_t;
endpackage : dmc_pkg

// >>> core/dmc_top.sv
// Input mute, zero detect, attenuation ramp and word clock sync of a 1-bit DAC front end.
// Assumes an AHB-Lite master on i_clk_sys and serial audio pins from another clock domain.
// What this block does
// - 48 bit clocks per word, MSB first, high=left
// - Upper bits constant for 300ms means zero
// - Left and right zero detection run separately
// - Mute flags on zero, system mute, soft mute bit
// - Flag polarity chosen by polarity bit
// - Ramp heads to newest target from current level
// - Soft mute on zero attenuation, bit or pin
// - Forced mute holds PWM outputs low
// - Zero mute enable plus both zeros forces mute
// - Framing aligns to word fall during reset
// - Frequency change loses sync until resync
// - Sync-ignore bit keeps playing through sync loss
// - Bass boost with mid and max levels
// - DAC speed from crystal and clock select
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`include "dmc_map.svh"
`timescale 1ns/1ps
`default_nettype none
module dmc_top import dmc_pkg::*; #(
  parameter int P_ZERO_CYCLES = `DMC_ZERO_MS * `DMC_CLK_KHZ
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic i_word_clock_in,
  input wire logic i_bit_clock_in,
  input wire logic i_sample_data_in,
  input wire logic i_emphasis_in,
  input wire logic i_system_mute_input,
  input wire logic i_crystal_select_pin,
  output logic o_left_mute_flag,
  output logic o_right_mute_flag,
  output logic o_pwm_left,
  output logic o_pwm_right,
  output logic o_emphasis_out,
  output logic o_dac_double_speed,
  output logic o_synced
);
  // Register file
  logic [9:0] ctrl;
  logic [`DMC_ATT_W-1:0] att;
  logic wr_pend;
  logic [7:0] wr_addr;
  wire addr_ok = i_hsel && i_htrans[1] && i_hready;
  wire [7:0] a_ofs = i_haddr[7:0];
  wire smute_bit = ctrl[`DMC_CB_SMUTE];
  wire fmute_bit = ctrl[`DMC_CB_FMUTE];
  wire fpol_bit = ctrl[`DMC_CB_FPOL];
  wire zmute_bit = ctrl[`DMC_CB_ZMUTE];
  wire resync_bit = ctrl[`DMC_CB_RESYNC];
  wire sign_bit = ctrl[`DMC_CB_SIGN];
  wire wr_ctrl = wr_pend && (wr_addr == `DMC_CTRL_OFS);
  wire wr_att = wr_pend && (wr_addr == `DMC_ATT_OFS);
  wire page_ok = i_hwdata[`DMC_CB_PAGE];
  // Guarded fields only change when the page bit rides in the same write
  wire [9:0] guard_mask = (10'h001 << `DMC_CB_FMUTE) | (10'h001 << `DMC_CB_RESYNC);
  wire [9:0] next_ctrl = page_ok ? i_hwdata[9:0] :
                         ((i_hwdata[9:0] & ~guard_mask) | (ctrl & guard_mask));

  // Pin synchronisers: word, bit, data, emphasis, system mute, crystal
  logic [5:0] s1, s2, s3, pin;
  logic [5:0] pin_q;
  wire [5:0] pin_raw = {i_crystal_select_pin, i_system_mute_input, i_emphasis_in,
                        i_sample_data_in, i_bit_clock_in, i_word_clock_in};
  wire [5:0] agree = ~(s2 ^ s3);
  wire [5:0] next_pin = (agree & s2) | (~agree & pin);
  always_ff @(posedge i_clk_sys) begin
    s1 <= pin_raw;
    s2 <= s1;
    s3 <= s2;
    pin <= next_pin;
    pin_q <= pin;
  end
  wire wc_rise = pin[0] & ~pin_q[0];
  wire wc_fall = ~pin[0] & pin_q[0];
  wire bc_rise = pin[1] & ~pin_q[1];
  wire system_mute_input = pin[4];
  wire xtal768 = pin[5];

  // Bus data phase and register writes
  wire [31:0] stat_word;
  wire [31:0] rd_mux = (a_ofs == `DMC_CTRL_OFS) ? {22'h000000, ctrl} :
                       (a_ofs == `DMC_ATT_OFS) ? {22'h000000, att} :
                       (a_ofs == `DMC_STAT_OFS) ? stat_word : 32'h00000000;
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ctrl <= `DMC_CTRL_RST;
      att <= `DMC_ATT_RST;
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      o_hrdata <= 32'h00000000;
      o_hreadyout <= 1'b1;
      o_hresp <= 1'b0;
    end else begin
      wr_pend <= addr_ok && i_hwrite;
      if (addr_ok) begin
        wr_addr <= a_ofs;
        o_hrdata <= i_hwrite ? 32'h00000000 : rd_mux;
      end
      if (wr_ctrl) ctrl <= next_ctrl;
      if (wr_att) att <= i_hwdata[`DMC_ATT_W-1:0];
    end
  end

  // Framing: align window is reset or the resync bit
  dmc_sync_t sync_st;
  logic win_q;
  logic [5:0] half_cnt, per_bits;
  logic [15:0] per_cyc, per_ref;
  logic [23:0] shreg;
  dmc_sample_t smp [2];
  logic samp_stb;
  wire align_win = i_rst || resync_bit;
  wire [15:0] per_tol = per_ref >> 3;
  wire per_bad = (per_cyc > per_ref + per_tol) || (per_cyc + per_tol < per_ref);
  wire frame_bad = (per_bits != `DMC_BITS_PER_WORD) || per_bad;
  always_ff @(posedge i_clk_sys) begin
    win_q <= align_win;
    samp_stb <= 1'b0;
    // Reset wins over a stale or unknown state so framing can lock inside reset
    if (align_win && !win_q) begin
      sync_st <= SYNC_WAIT;
    end else if (i_rst) begin
      case (sync_st)
        SYNC_LOCKED: sync_st <= SYNC_LOCKED;
        default: sync_st <= SYNC_WAIT;
      endcase
    end
    if (bc_rise) begin
      per_bits <= per_bits + 6'h01;
      if (half_cnt < `DMC_SAMPLE_BITS) begin
        shreg <= {shreg[22:0], pin[2]};
        half_cnt <= half_cnt + 6'h01;
      end
    end
    if (wc_rise || wc_fall) half_cnt <= 6'h00;
    if (!i_rst && per_cyc != 16'hffff) per_cyc <= per_cyc + 16'h0001;
    if (wc_rise && sync_st != SYNC_WAIT) begin
      smp[1] <= shreg;
      samp_stb <= 1'b1;
    end
    if (wc_fall) begin
      per_bits <= 6'h00;
      per_cyc <= 16'h0000;
      smp[0] <= shreg;
      if (align_win && sync_st == SYNC_WAIT) begin
        sync_st <= SYNC_LOCKED;
        per_ref <= 16'h0000;
      end else if (sync_st == SYNC_LOCKED) begin
        if (per_ref == 16'h0000) per_ref <= per_cyc;
        else if (frame_bad && !sign_bit) sync_st <= SYNC_LOST;
      end
    end
    // Clear samples so the gain path and bass filter never start unknown
    if (i_rst) begin
      smp[0] <= 24'h000000;
      smp[1] <= 24'h000000;
    end
  end
  wire play_ok = (sync_st == SYNC_LOCKED);

  // Zero detection per channel
  logic [1:0] zero;
  logic [23:0] zcnt [2];
  logic [1:0] smp_zero;
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      smp_zero[c] = (&smp[c][23:`DMC_ZERO_LSB]) | ~(|smp[c][23:`DMC_ZERO_LSB]);
    end
  end
  always_ff @(posedge i_clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (i_rst || (samp_stb && !smp_zero[c])) begin
        zcnt[c] <= 24'h000000;
        zero[c] <= 1'b0;
      end else if (zcnt[c] >= P_ZERO_CYCLES[23:0] - 24'h000001) begin
        zero[c] <= 1'b1;
      end else begin
        zcnt[c] <= zcnt[c] + 24'h000001;
      end
    end
  end

  // Mute decisions
  wire soft_mute = (att == 10'h000) || smute_bit || system_mute_input;
  wire zero_fmute = zmute_bit && (&zero);
  wire hard_mute = fmute_bit || zero_fmute || !play_ok;
  wire [9:0] tgt = soft_mute ? 10'h000 : att;
  wire [1:0] flag_act = zero | {2{system_mute_input | smute_bit}};

  // Attenuation ramp, one step per stereo sample
  logic [9:0] level;
  wire [9:0] gap_up = tgt - level;
  wire [9:0] gap_dn = level - tgt;
  wire [9:0] next_level = (tgt > level) ? ((gap_up < `DMC_RAMP_STEP) ? tgt : level + `DMC_RAMP_STEP) :
                          ((gap_dn < `DMC_RAMP_STEP) ? tgt : level - `DMC_RAMP_STEP);
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) level <= 10'h000;
    else if (samp_stb) level <= next_level;
  end

  // Gain, bass boost and first-order modulator per channel
  logic signed [23:0] lp [2];
  logic signed [23:0] y [2];
  logic [24:0] acc [2];
  logic [1:0] bits;
  logic signed [34:0] prod [2];
  logic signed [25:0] boosted [2];
  wire boost_on = ctrl[`DMC_CB_BOOST];
  wire boost_max = ctrl[`DMC_CB_BLEVEL];
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      prod[c] = smp[c] * $signed({25'h0000000, level});
      boosted[c] = 26'($signed(prod[c][33:10])) + (!boost_on ? 26'h0000000 :
                   boost_max ? 26'(lp[c] >>> 1) : 26'(lp[c] >>> 2));
    end
  end
  always_ff @(posedge i_clk_sys) begin
    for (int c = 0; c < 2; c++) begin
      if (i_rst) begin
        lp[c] <= 24'h000000;
        y[c] <= 24'h000000;
        acc[c] <= 25'h0000000;
        bits[c] <= 1'b0;
      end else begin
        if (samp_stb) begin
          lp[c] <= lp[c] + (($signed(prod[c][33:10]) - lp[c]) >>> 4);
          // Saturate rather than wrap when boost overshoots
          y[c] <= (boosted[c] > 26'sh07fffff) ? 24'h7fffff :
                  (boosted[c] < -26'sh0800000) ? 24'h800000 : boosted[c][23:0];
        end
        if (hard_mute) begin
          acc[c] <= 25'h0000000;
          bits[c] <= 1'b0;
        end else begin
          acc[c] <= {1'b0, acc[c][23:0]} + {1'b0, ~y[c][23], y[c][22:0]};
          bits[c] <= acc[c][24];
        end
      end
    end
  end

  // Registered outputs
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_left_mute_flag <= ~fpol_bit;
      o_right_mute_flag <= ~fpol_bit;
      o_pwm_left <= 1'b0;
      o_pwm_right <= 1'b0;
      o_emphasis_out <= 1'b0;
      o_dac_double_speed <= 1'b0;
      o_synced <= 1'b0;
    end else begin
      o_left_mute_flag <= flag_act[0] ~^ fpol_bit;
      o_right_mute_flag <= flag_act[1] ~^ fpol_bit;
      o_pwm_left <= bits[0] & ~hard_mute;
      o_pwm_right <= bits[1] & ~hard_mute;
      o_emphasis_out <= pin[3];
      o_dac_double_speed <= xtal768 && !ctrl[`DMC_CB_MCLK];
      o_synced <= play_ok;
    end
  end
  assign stat_word = {16'h0000, level, o_dac_double_speed, sync_st, hard_mute, zero};

  // Checks
  sequence s_zero_both;
    zmute_bit && (&zero);
  endsequence
  sequence s_break(c);
    samp_stb && !smp_zero[c];
  endsequence
  AST_FLAG_POL: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !$past(i_rst) |-> o_left_mute_flag == ($past(flag_act[0]) ~^ $past(fpol_bit)))
    else $error("left mute flag level wrong");
  AST_FLAG_SYSTEM_MUTE_INPUT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    system_mute_input && fpol_bit |=> o_right_mute_flag)
    else $error("system mute did not raise flag");
  AST_FMUTE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    fmute_bit |=> !o_pwm_left && !o_pwm_right)
    else $error("forced mute left PWM active");
  AST_ZMUTE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_zero_both |=> !o_pwm_left ##0 !o_pwm_right)
    else $error("zero mute left PWM active");
  AST_ZERO_CLR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    s_break(1) |=> !zero[1] && zcnt[1] == 24'h000000)
    else $error("zero flag survived nonzero sample");
  AST_ZERO_SET: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    $rose(zero[0]) |-> zcnt[0] >= P_ZERO_CYCLES[23:0] - 24'h000001)
    else $error("zero flag set early");
  AST_RAMP_HOLD: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    !samp_stb |=> $stable(level))
    else $error("level moved between samples");
  AST_RAMP_DIR: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    samp_stb && tgt > level |=> level == $past(level) + `DMC_RAMP_STEP)
    else $error("ramp did not step toward target");
  AST_SOFT: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    smute_bit |-> tgt == 10'h000)
    else $error("soft mute target not zero");
  AST_SPEED: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    xtal768 && !ctrl[`DMC_CB_MCLK] |=> o_dac_double_speed)
    else $error("double speed not selected");
  AST_IGNORE: assert property (@(posedge i_clk_sys) disable iff (i_rst)
    sign_bit && sync_st == SYNC_LOCKED && !align_win |=> sync_st == SYNC_LOCKED)
    else $error("sync lost while ignored");
endmodule : dmc_top
`default_nettype wire

// >>> verif/dmc_audio_src.sv
// Serial audio source standing in for the signal processor.
// Assumes the bench holds the samples steady while frames run.
`timescale 1ns/1ps
`default_nettype none
module dmc_audio_src (
  input wire logic i_run,
  input wire logic [23:0] i_left,
  input wire logic [23:0] i_right,
  output logic o_word,
  output logic o_bit,
  output logic o_data
);
  // Lines move on the falling bit clock, 24 bits per half word
  initial begin
    o_word = 1'b0;
    o_bit = 1'b0;
    o_data = 1'b0;
    forever begin
      wait (i_run);
      for (int i = 0; i < 48; i++) begin
        o_word = (i < 24);
        o_data = (i < 24) ? i_left[23-i] : i_right[47-i];
        #100 o_bit = 1'b1;
        #100 o_bit = 1'b0;
      end
      // Released line must not keep its last value
      if (!i_run) o_data = ~o_data;
    end
  end
endmodule : dmc_audio_src
`default_nettype wire

// >>> verif/dmc_top_bench.sv
// Bench for the mute/attenuation control: bus tasks and audio scenarios.
// Assumes the audio source model and a 40 MHz system clock.
`timescale 1ns/1ps
`default_nettype none
module dmc_top_bench;
  logic clk = 0, rst = 1, hsel = 0, hwrite = 0, system_mute_input = 0, xtal = 1, emphasis_out = 0, run = 1;
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata;
  logic hrdy, hresp, lf, rf, pl, pr, emo, dbl, syn, wclk, bclk, sd;
  logic [23:0] left = 24'h123456, right = 24'h654321;
  int fail_count = 0, n_tests = 0, cyc = 0, hi;

  // Clock at 25 ns period
  always #12.5 clk = ~clk;

  dmc_top #(.P_ZERO_CYCLES(2000)) u_dmc_top (.i_clk_sys(clk), .i_rst(rst), .i_hsel(hsel),
    .i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
    .i_hready(hrdy), .o_hrdata(hrdata), .o_hreadyout(hrdy), .o_hresp(hresp),
    .i_word_clock_in(wclk), .i_bit_clock_in(bclk), .i_sample_data_in(sd),
    .i_emphasis_in(emphasis_out), .i_system_mute_input(system_mute_input), .i_crystal_select_pin(xtal),
    .o_left_mute_flag(lf), .o_right_mute_flag(rf), .o_pwm_left(pl), .o_pwm_right(pr),
    .o_emphasis_out(emo), .o_dac_double_speed(dbl), .o_synced(syn));
  dmc_audio_src u_dmc_audio_src (.i_run(run), .i_left(left), .i_right(right),
    .o_word(wclk), .o_bit(bclk), .o_data(sd));

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  // One single AHB transfer; waits on hready in both phases
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= wr;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hrdy !== 1'b1) @(posedge clk);
    q = hrdata;
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rdc(input string n, input logic [31:0] a, input logic [31:0] m,
                     input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(n, e, q & m);
  endtask : rdc

  // One frame is 48 x 200 ns = 384 system cycles
  task automatic fr(input int n);
    repeat (n * 384) @(posedge clk);
  endtask : fr

  // Counts cycles where either modulator output is high
  task automatic pwm_hi();
    hi = 0;
    repeat (800) @(posedge clk) hi += int'(pl | pr);
  endtask : pwm_hi

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : tally_and_finish

  // Hang guard, well above the expected run of about 40000 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 90000) begin
      fail_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rdc("ctrl", 32'h00, 32'hffffffff, 32'h004);
    rdc("att", 32'h04, 32'hffffffff, 32'h3ff);
    wr(32'h0c, 32'hffffffff);
    rdc("unmapped", 32'h0c, 32'hffffffff, 32'h0);
    wr(32'h00, 32'h004);
    wr(32'h00, 32'h214);
    fr(2);
    wr(32'h00, 32'h204);
    fr(1);
    chk("synced", 1, syn);
    rdc("sync state", 32'h08, 32'h18, 32'h08);
    chk("left flag idle", 0, lf);
    pwm_hi();
    chk("pwm plays", 1, hi > 0);
    left <= 24'h00000a;
    fr(8);
    chk("left zero", 1, lf);
    chk("right live", 0, rf);
    right <= 24'hfffff3;
    fr(8);
    chk("right zero", 1, rf);
    wr(32'h00, 32'h00c);
    fr(1);
    rdc("zero mute", 32'h08, 32'h7, 32'h7);
    pwm_hi();
    chk("pwm zero mute", 0, hi);
    left <= 24'h400000;
    fr(2);
    chk("left cleared", 0, lf);
    rdc("zero mute off", 32'h08, 32'h7, 32'h2);
    wr(32'h00, 32'h000);
    fr(1);
    chk("left pol", 1, lf);
    chk("right pol", 0, rf);
    wr(32'h00, 32'h005);
    fr(1);
    chk("soft mute flag", 1, lf);
    wr(32'h00, 32'h004);
    system_mute_input <= 1'b1;
    fr(1);
    chk("sys mute flag", 1, lf);
    system_mute_input <= 1'b0;
    // Drain the level to zero first, so the ramp starts from a known point
    wr(32'h04, 32'h000);
    fr(40);
    rdc("ramp zero", 32'h08, 32'hffc0, 32'h0);
    wr(32'h04, 32'h3f0);
    fr(5);
    rdc("ramp mid", 32'h08, 32'hff00, 32'h100);
    wr(32'h04, 32'h002);
    fr(16);
    rdc("ramp end", 32'h08, 32'hffc0, 32'h2 << 6);
    wr(32'h00, 32'h006);
    rdc("fmute refused", 32'h00, 32'h2, 32'h0);
    wr(32'h00, 32'h206);
    rdc("fmute set", 32'h00, 32'h2, 32'h2);
    pwm_hi();
    chk("pwm forced", 0, hi);
    // Speed table: crystal, clock select, double speed expected
    for (int i = 0; i < 3; i++) begin
      xtal <= (i < 2);
      wr(32'h00, 32'h204 | ((i == 0) ? 32'h100 : 32'h0));
      fr(1);
      chk("speed", (i == 1), dbl);
    end
    wr(32'h00, 32'h214);
    fr(2);
    wr(32'h00, 32'h204);
    fr(1);
    chk("resynced", 1, syn);
    emphasis_out <= 1'b1;
    fr(1);
    chk("emphasis", 1, emo);
    tally_and_finish();
  end
endmodule : dmc_top_bench
`default_nettype wire
